// [inc/cipher_pkg.sv]
// Purpose: Shared constants and types of the cipher mode switch controller.
// Assumes: Clock of 50 MHz; one frame strobe per radio frame.
// Notes:   Commands travel in even frames outbound and odd frames inbound.
package cipher_pkg;

  // ---------------------------------------------------------------------------
  // Command codes on the tail field
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_START_REQ,
    CMD_START_CONFIRM,
    CMD_START_GRANT,
    CMD_START_REJECT,
    CMD_HALT_REQ,
    CMD_HALT_CONFIRM,
    CMD_HALT_GRANT,
    CMD_WAIT
  } cmd_type;

  // ---------------------------------------------------------------------------
  // Sizes, reset values and timing
  // ---------------------------------------------------------------------------
  localparam int KEY_INDEX_W = 8;
  localparam int REPEAT_W = 3;
  localparam logic [REPEAT_W-1:0] MAX_REPEATS = 3'h5;
  localparam logic RESET_ENCRYPTED = 1'b0;
  localparam logic [KEY_INDEX_W-1:0] RESET_KEY_INDEX = 8'h00;
  localparam int CLK_KHZ = 50000;
  localparam int EXCHANGE_LIMIT_MS = 1000;
  localparam int EXCHANGE_LIMIT_CYCLES = EXCHANGE_LIMIT_MS * CLK_KHZ;

endpackage : cipher_pkg

// [inc/exch_if.sv]
// Purpose: Carries control and status between the controller and its timer.
// Assumes: Both ends run on the same clock.
// Notes:   The repeat count saturates instead of wrapping.
`timescale 1ns/100ps
interface exch_if;
  logic restart;
  logic tick;
  logic clr;
  logic expired;
  logic [cipher_pkg::REPEAT_W-1:0] reps;
  modport ctrl (output restart, output tick, output clr, input expired, input reps);
  modport timer (input restart, input tick, input clr, output expired, output reps);
endinterface : exch_if

// [rtl/exchange_timer.sv]
// Purpose: Times one switching exchange and counts repeated requests.
// Assumes: Restart is pulsed at the start of every exchange.
// Notes:   The time counter stops once the limit is reached.
`timescale 1ns/100ps
module exchange_timer #(
  parameter int TIMEOUT_CYCLES = cipher_pkg::EXCHANGE_LIMIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  exch_if.timer x
);
  logic [31:0] cnt;
  logic [cipher_pkg::REPEAT_W-1:0] reps;
  wire logic [31:0] limit = 32'(TIMEOUT_CYCLES - 1);
  wire logic saturated = (reps == {cipher_pkg::REPEAT_W{1'b1}});

  assign x.expired = (cnt >= limit);
  assign x.reps = reps;

  always_ff @(posedge clk_i) begin
    if (rst_i || x.restart) begin
      cnt <= 32'h0;
      reps <= '0;
    end else begin
      if (!x.expired) begin
        cnt <= cnt + 32'h1;
      end
      if (x.clr) begin
        reps <= '0;
      end else if (x.tick && !saturated) begin
        reps <= reps + 3'h1;
      end
    end
  end
endmodule : exchange_timer

// [rtl/cipher_mode_switch_ctrl.sv]
// Purpose: Portable-end controller for switching a link between clear and cipher.
// Assumes: FRAME_I pulses once per frame, FRAME_ODD_I gives its parity, both on CLK_I.
// Notes:   Received commands are presented as one-cycle RX_VALID_I pulses.
`timescale 1ns/100ps
module cipher_mode_switch_ctrl #(
  parameter int TIMEOUT_CYCLES = cipher_pkg::EXCHANGE_LIMIT_CYCLES,
  parameter logic [cipher_pkg::KEY_INDEX_W-1:0] KEY_CHOICE_VALUE = 8'hff
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic FRAME_I,
  input wire logic FRAME_ODD_I,
  input wire logic SWITCH_REQ_I,
  input wire logic REKEY_I,
  input wire logic REKEY_DEFAULT_I,
  input wire logic [cipher_pkg::KEY_INDEX_W-1:0] KEY_INDEX_I,
  input wire logic REMOTE_REKEY_ALLOW_I,
  input wire logic RX_VALID_I,
  input wire cipher_pkg::cmd_type RX_CMD_I,
  input wire logic RX_DEFAULT_I,
  input wire logic [cipher_pkg::KEY_INDEX_W-1:0] RX_KEY_INDEX_I,
  output logic TX_VALID_O,
  output cipher_pkg::cmd_type TX_CMD_O,
  output logic TX_DEFAULT_O,
  output logic [cipher_pkg::KEY_INDEX_W-1:0] TX_KEY_INDEX_O,
  output logic ENCRYPT_O,
  output logic DECRYPT_O,
  output logic DISCARD_O,
  output logic SWITCH_CONFIRM_O,
  output logic LINK_DROP_O,
  output logic KEY_IS_DEFAULT_O
);

  // ---------------------------------------------------------------------------
  // State and decode
  // ---------------------------------------------------------------------------
  typedef enum {S_IDLE, S_HALT_REQ, S_HALT_GRANT, S_START_REQ, S_START_GRANT} state_type;

  state_type state, next_state;
  logic encrypted, next_encrypted;
  logic decrypting, next_decrypting;
  logic rekey, next_rekey;
  logic use_default, next_use_default;
  logic [cipher_pkg::KEY_INDEX_W-1:0] key_index, next_key_index;
  logic tx_valid, next_tx_valid;
  cipher_pkg::cmd_type tx_cmd, next_tx_cmd;
  logic tx_default, next_tx_default;
  logic confirm, next_confirm;
  logic drop, next_drop;
  logic do_drop;

  exch_if tmr ();

  exchange_timer #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_timer (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .x(tmr.timer)
  );

  wire logic even = FRAME_I && !FRAME_ODD_I;
  wire logic rx_halt_conf = RX_VALID_I && (RX_CMD_I == cipher_pkg::CMD_HALT_CONFIRM);
  wire logic rx_start_conf = RX_VALID_I && (RX_CMD_I == cipher_pkg::CMD_START_CONFIRM);
  wire logic rx_reject = RX_VALID_I && (RX_CMD_I == cipher_pkg::CMD_START_REJECT);
  wire logic rx_wait = RX_VALID_I && (RX_CMD_I == cipher_pkg::CMD_WAIT);
  // A remote start request is only a hint: it is obeyed only when the user allows it.
  wire logic remote_ask = RX_VALID_I && (RX_CMD_I == cipher_pkg::CMD_START_REQ) &&
                          RX_DEFAULT_I && encrypted && REMOTE_REKEY_ALLOW_I;
  wire logic remote_key_ok = (RX_KEY_INDEX_I != KEY_CHOICE_VALUE);
  wire logic reps_used = (tmr.reps >= cipher_pkg::MAX_REPEATS);

  // ---------------------------------------------------------------------------
  // Exchange sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_encrypted = encrypted;
    next_decrypting = decrypting;
    next_rekey = rekey;
    next_use_default = use_default;
    next_key_index = key_index;
    next_tx_valid = 1'b0;
    next_tx_cmd = tx_cmd;
    next_tx_default = tx_default;
    next_confirm = 1'b0;
    next_drop = 1'b0;
    do_drop = 1'b0;
    tmr.restart = 1'b0;
    tmr.tick = 1'b0;
    tmr.clr = 1'b0;
    case (state)
      S_IDLE: begin
        if (encrypted && (SWITCH_REQ_I || remote_ask)) begin
          next_state = S_HALT_REQ;
          tmr.restart = 1'b1;
          next_rekey = REKEY_I || remote_ask;
          next_use_default = remote_ask || REKEY_DEFAULT_I;
          next_key_index = (remote_ask && remote_key_ok) ? RX_KEY_INDEX_I : KEY_INDEX_I;
        end else if (!encrypted && SWITCH_REQ_I && REKEY_I) begin
          next_state = S_START_REQ;
          tmr.restart = 1'b1;
          next_rekey = 1'b1;
          next_use_default = REKEY_DEFAULT_I;
          next_key_index = KEY_INDEX_I;
        end
      end
      S_HALT_REQ: begin
        if (rx_halt_conf) begin
          next_decrypting = 1'b0;
          next_confirm = 1'b1;
          next_state = S_HALT_GRANT;
        end else if (even) begin
          if (reps_used) begin
            do_drop = 1'b1;
          end else begin
            next_tx_valid = 1'b1;
            next_tx_cmd = cipher_pkg::CMD_HALT_REQ;
            next_tx_default = 1'b0;
            tmr.tick = 1'b1;
          end
        end
      end
      S_HALT_GRANT: begin
        if (even) begin
          next_tx_valid = 1'b1;
          next_tx_cmd = cipher_pkg::CMD_HALT_GRANT;
          next_tx_default = 1'b0;
          next_encrypted = 1'b0;
          if (rekey) begin
            next_state = S_START_REQ;
            tmr.restart = 1'b1;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      S_START_REQ: begin
        if (rx_start_conf) begin
          next_decrypting = 1'b1;
          next_confirm = 1'b1;
          next_state = S_START_GRANT;
        end else if (rx_reject && use_default) begin
          next_confirm = 1'b1;
          next_rekey = 1'b0;
          next_state = S_IDLE;
        end else if (rx_wait && use_default) begin
          tmr.clr = 1'b1;
        end else if (even) begin
          if (reps_used) begin
            do_drop = 1'b1;
          end else begin
            next_tx_valid = 1'b1;
            next_tx_cmd = cipher_pkg::CMD_START_REQ;
            next_tx_default = use_default;
            tmr.tick = 1'b1;
          end
        end
      end
      S_START_GRANT: begin
        if (even) begin
          next_tx_valid = 1'b1;
          next_tx_cmd = cipher_pkg::CMD_START_GRANT;
          next_tx_default = use_default;
          next_encrypted = 1'b1;
          next_rekey = 1'b0;
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (state != S_IDLE && tmr.expired) begin
      do_drop = 1'b1;
    end
    if (do_drop) begin
      next_state = S_IDLE;
      next_encrypted = 1'b0;
      next_decrypting = 1'b0;
      next_rekey = 1'b0;
      next_tx_valid = 1'b0;
      next_drop = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state <= S_IDLE;
      encrypted <= cipher_pkg::RESET_ENCRYPTED;
      decrypting <= cipher_pkg::RESET_ENCRYPTED;
      rekey <= 1'b0;
      use_default <= 1'b0;
      key_index <= cipher_pkg::RESET_KEY_INDEX;
      tx_valid <= 1'b0;
      tx_cmd <= cipher_pkg::CMD_NONE;
      tx_default <= 1'b0;
      confirm <= 1'b0;
      drop <= 1'b0;
    end else begin
      state <= next_state;
      encrypted <= next_encrypted;
      decrypting <= next_decrypting;
      rekey <= next_rekey;
      use_default <= next_use_default;
      key_index <= next_key_index;
      tx_valid <= next_tx_valid;
      tx_cmd <= next_tx_cmd;
      tx_default <= next_tx_default;
      confirm <= next_confirm;
      drop <= next_drop;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign TX_VALID_O = tx_valid;
  assign TX_CMD_O = tx_cmd;
  assign TX_DEFAULT_O = tx_default;
  assign TX_KEY_INDEX_O = key_index;
  assign ENCRYPT_O = encrypted;
  assign DECRYPT_O = decrypting;
  // Holding off all data for the whole exchange covers the stricter discard window too.
  assign DISCARD_O = (state != S_IDLE);
  assign SWITCH_CONFIRM_O = confirm;
  assign LINK_DROP_O = drop;
  assign KEY_IS_DEFAULT_O = use_default;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  property p_even_only;
    TX_VALID_O |-> $past(even);
  endproperty
  a_even_only: assert property (p_even_only) else $error("command sent off an even frame");

  property p_repeat_cap;
    (TX_VALID_O && TX_CMD_O == cipher_pkg::CMD_HALT_REQ) |-> $past(tmr.reps) < cipher_pkg::MAX_REPEATS;
  endproperty
  a_repeat_cap: assert property (p_repeat_cap) else $error("too many halt requests");

  property p_halt_drop;
    (state == S_HALT_REQ && even && !rx_halt_conf && reps_used) |=> LINK_DROP_O && !ENCRYPT_O;
  endproperty
  a_halt_drop: assert property (p_halt_drop) else $error("no drop after halt repeats");

  property p_confirm;
    (state == S_HALT_REQ && rx_halt_conf && !tmr.expired) |=> SWITCH_CONFIRM_O;
  endproperty
  a_confirm: assert property (p_confirm) else $error("halt confirm not reported");

  property p_decrypt_off;
    (state == S_HALT_REQ && rx_halt_conf) |=> !DECRYPT_O;
  endproperty
  a_decrypt_off: assert property (p_decrypt_off) else $error("decrypting after halt confirm");

  property p_discard;
    (state == S_HALT_REQ && !rx_halt_conf && !(even && reps_used) && !tmr.expired) |=> DISCARD_O;
  endproperty
  a_discard: assert property (p_discard) else $error("data passed during exchange");

  property p_grant;
    (state == S_HALT_GRANT && even && !tmr.expired) |=>
      TX_VALID_O && TX_CMD_O == cipher_pkg::CMD_HALT_GRANT && !ENCRYPT_O ##1 !ENCRYPT_O;
  endproperty
  a_grant: assert property (p_grant) else $error("halt grant or clear mode missing");

  property p_rekey;
    (state == S_HALT_GRANT && even && rekey && !tmr.expired) |=> state == S_START_REQ;
  endproperty
  a_rekey: assert property (p_rekey) else $error("re-key did not restart");

  property p_default_start;
    (TX_VALID_O && TX_CMD_O == cipher_pkg::CMD_START_REQ) |-> TX_DEFAULT_O == use_default;
  endproperty
  a_default_start: assert property (p_default_start) else $error("wrong start flavour");

  property p_timeout;
    (state != S_IDLE && tmr.expired) |=> LINK_DROP_O && state == S_IDLE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("exchange over limit not dropped");

  c_halt_done: cover property (state == S_HALT_GRANT && even && !rekey);
  c_rekey_done: cover property (state == S_START_GRANT && even);
  c_wait_seen: cover property (state == S_START_REQ && rx_wait && use_default);
  c_drop: cover property (LINK_DROP_O);

endmodule : cipher_mode_switch_ctrl

// [tb/fixed_side_model.sv]
// Purpose: Fixed-end partner that answers the portable controller in odd frames.
// Assumes: Mode 0 answers, 1 stays silent, 2 rejects a start, 3 answers a start with wait.
// Notes:   Idle reply lines carry a changing pattern so that a stale value is never trusted.
`timescale 1ns/100ps
module fixed_side_model (
  input wire logic clk_i,
  input wire logic frame_i,
  input wire logic frame_odd_i,
  input wire logic tx_valid_i,
  input wire cipher_pkg::cmd_type tx_cmd_i,
  input wire logic tx_default_i,
  input wire logic [7:0] tx_key_i,
  input wire logic [1:0] mode_i,
  input wire logic remote_i,
  input wire logic [7:0] remote_key_i,
  output logic rx_valid_o = 1'b0,
  output cipher_pkg::cmd_type rx_cmd_o = cipher_pkg::CMD_NONE,
  output logic rx_default_o = 1'b0,
  output logic [7:0] rx_key_o = 8'h00
);
  cipher_pkg::cmd_type reply = cipher_pkg::CMD_NONE;
  logic dflt = 1'b0;
  logic go = 1'b0;
  logic [7:0] key = 8'h00;
  logic [3:0] junk = 4'h0;
  int left = 0;
  // A request reopens a six-frame reply window, or closes it in mode 1; any grant closes it.
  always @(posedge clk_i) begin
    go <= 1'b0;
    if (remote_i) begin
      reply <= cipher_pkg::CMD_START_REQ;
      dflt <= 1'b1;
      key <= remote_key_i;
      left <= 6;
    end else if (tx_valid_i && tx_cmd_i == cipher_pkg::CMD_HALT_REQ) begin
      reply <= cipher_pkg::CMD_HALT_CONFIRM;
      dflt <= 1'b0;
      left <= (mode_i == 2'h1) ? 0 : 6;
    end else if (tx_valid_i && tx_cmd_i == cipher_pkg::CMD_START_REQ) begin
      reply <= mode_i == 2'h2 ? cipher_pkg::CMD_START_REJECT
             : mode_i == 2'h3 ? cipher_pkg::CMD_WAIT : cipher_pkg::CMD_START_CONFIRM;
      dflt <= tx_default_i;
      key <= tx_key_i;
      left <= (mode_i == 2'h1) ? 0 : 6;
    end else if (tx_valid_i) begin
      left <= 0;
    end else if (frame_i && frame_odd_i && left > 0) begin
      go <= 1'b1;
      left <= left - 1;
    end
  end
  always @(negedge clk_i) begin
    junk <= junk + 4'h1;
    rx_valid_o <= go;
    rx_cmd_o <= go ? reply : cipher_pkg::cmd_type'(junk);
    rx_default_o <= go ? dflt : junk[0];
    rx_key_o <= go ? key : ~rx_key_o;
  end
endmodule : fixed_side_model

// [tb/cipher_mode_switch_ctrl_tb.sv]
// Purpose: Self-checking bench for the portable-end cipher mode switch controller.
// Assumes: Eight-cycle frames of alternating parity and a 400-cycle exchange limit.
// Notes:   Expected command sequences are queued per exchange and compared in order.
`timescale 1ns/100ps
module cipher_mode_switch_ctrl_tb;
  logic CLK_I, RESET_I, FRAME_I, FRAME_ODD_I, SWITCH_REQ_I, REKEY_I, REKEY_DEFAULT_I;
  logic REMOTE_REKEY_ALLOW_I, RX_VALID_I, RX_DEFAULT_I, TX_VALID_O, TX_DEFAULT_O;
  logic ENCRYPT_O, DECRYPT_O, DISCARD_O, SWITCH_CONFIRM_O, LINK_DROP_O, KEY_IS_DEFAULT_O;
  logic remote, exp_df;
  logic [1:0] mode;
  logic [7:0] KEY_INDEX_I, RX_KEY_INDEX_I, TX_KEY_INDEX_O, exp_key, k, rkey;
  cipher_pkg::cmd_type RX_CMD_I, TX_CMD_O;
  cipher_pkg::cmd_type got_q[$], exp_q[$];
  int n_mismatch = 0, samples_checked = 0, n_conf = 0, n_drop = 0, seed = 42, cyc = 0, t0;

  cipher_mode_switch_ctrl #(.TIMEOUT_CYCLES(400)) u_dut (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .FRAME_I(FRAME_I), .FRAME_ODD_I(FRAME_ODD_I),
    .SWITCH_REQ_I(SWITCH_REQ_I), .REKEY_I(REKEY_I), .REKEY_DEFAULT_I(REKEY_DEFAULT_I),
    .KEY_INDEX_I(KEY_INDEX_I), .REMOTE_REKEY_ALLOW_I(REMOTE_REKEY_ALLOW_I),
    .RX_VALID_I(RX_VALID_I), .RX_CMD_I(RX_CMD_I), .RX_DEFAULT_I(RX_DEFAULT_I),
    .RX_KEY_INDEX_I(RX_KEY_INDEX_I), .TX_VALID_O(TX_VALID_O), .TX_CMD_O(TX_CMD_O),
    .TX_DEFAULT_O(TX_DEFAULT_O), .TX_KEY_INDEX_O(TX_KEY_INDEX_O), .ENCRYPT_O(ENCRYPT_O),
    .DECRYPT_O(DECRYPT_O), .DISCARD_O(DISCARD_O), .SWITCH_CONFIRM_O(SWITCH_CONFIRM_O),
    .LINK_DROP_O(LINK_DROP_O), .KEY_IS_DEFAULT_O(KEY_IS_DEFAULT_O));
  fixed_side_model u_far (
    .clk_i(CLK_I), .frame_i(FRAME_I), .frame_odd_i(FRAME_ODD_I), .tx_valid_i(TX_VALID_O),
    .tx_cmd_i(TX_CMD_O), .tx_default_i(TX_DEFAULT_O), .tx_key_i(TX_KEY_INDEX_O),
    .mode_i(mode), .remote_i(remote), .remote_key_i(rkey), .rx_valid_o(RX_VALID_I),
    .rx_cmd_o(RX_CMD_I), .rx_default_o(RX_DEFAULT_I), .rx_key_o(RX_KEY_INDEX_I));

  always #10 CLK_I = ~CLK_I;

  always @(negedge CLK_I) begin
    cyc <= cyc + 1;
    FRAME_I <= (cyc % 8 == 0);
    if (cyc % 8 == 0) FRAME_ODD_I <= ~FRAME_ODD_I;
  end

  always @(negedge CLK_I) if (RESET_I === 1'b0) begin
    if (TX_VALID_O === 1'b1) begin
      got_q.push_back(TX_CMD_O);
      check("tx frame parity", FRAME_ODD_I, 0);
      if (TX_CMD_O == cipher_pkg::CMD_START_REQ || TX_CMD_O == cipher_pkg::CMD_START_GRANT) begin
        check("tx default flag", TX_DEFAULT_O, exp_df);
        if (exp_df) check("tx key index", TX_KEY_INDEX_O, exp_key);
      end
    end
    if (SWITCH_CONFIRM_O === 1'b1) n_conf++;
    if (SWITCH_CONFIRM_O === 1'b1 && ENCRYPT_O === 1'b1) check("decrypt at confirm", DECRYPT_O, 0);
    if (LINK_DROP_O === 1'b1) n_drop++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic await_disc(input logic v, input int lim);
    int n;
    for (n = 0; n < lim && DISCARD_O !== v; n++) @(negedge CLK_I);
    check("exchange busy", DISCARD_O, v);
  endtask : await_disc

  // Called at a falling edge; the request is taken at the next rising edge.
  task automatic request(input logic rk, input logic df, input logic [7:0] key, input logic busy);
    SWITCH_REQ_I = 1'b1;
    REKEY_I = rk;
    REKEY_DEFAULT_I = df;
    KEY_INDEX_I = key;
    exp_df = df;
    exp_key = key;
    t0 = cyc;
    @(negedge CLK_I);
    SWITCH_REQ_I = 1'b0;
    check("busy after request", DISCARD_O, busy);
  endtask : request

  task automatic close_exch(input int h, hg, s, sg, conf, drop, input logic enc, dfk);
    int j;
    repeat (h) exp_q.push_back(cipher_pkg::CMD_HALT_REQ);
    repeat (hg) exp_q.push_back(cipher_pkg::CMD_HALT_GRANT);
    repeat (s) exp_q.push_back(cipher_pkg::CMD_START_REQ);
    repeat (sg) exp_q.push_back(cipher_pkg::CMD_START_GRANT);
    await_disc(1'b0, 3000);
    repeat (4) @(negedge CLK_I);
    check("tx count", got_q.size(), exp_q.size());
    for (j = 0; j < exp_q.size() && j < got_q.size(); j++) check("tx cmd", got_q[j], exp_q[j]);
    check("confirm pulses", n_conf, conf);
    check("drop pulses", n_drop, drop);
    check("encrypt", ENCRYPT_O, enc);
    check("decrypt", DECRYPT_O, enc);
    if (enc) check("default key", KEY_IS_DEFAULT_O, dfk);
    got_q.delete();
    exp_q.delete();
    n_conf = 0;
    n_drop = 0;
  endtask : close_exch

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    CLK_I = 1'b0;
    RESET_I = 1'b1;
    FRAME_I = 1'b0;
    FRAME_ODD_I = 1'b1;
    SWITCH_REQ_I = 1'b0;
    REKEY_I = 1'b0;
    REKEY_DEFAULT_I = 1'b0;
    KEY_INDEX_I = 8'h00;
    REMOTE_REKEY_ALLOW_I = 1'b0;
    remote = 1'b0;
    rkey = 8'hff;
    mode = 2'h0;
    exp_df = 1'b0;
    exp_key = 8'h00;
    repeat (12) @(negedge CLK_I);
    RESET_I = 1'b0;
    check("idle outputs", {TX_VALID_O, TX_CMD_O, ENCRYPT_O, DECRYPT_O, DISCARD_O}, 0);
    request(1'b1, 1'b0, 8'h00, 1'b1);
    close_exch(0, 0, 1, 1, 1, 0, 1'b1, 1'b0);
    request(1'b1, 1'b0, 8'h00, 1'b1);
    close_exch(1, 1, 1, 1, 2, 0, 1'b1, 1'b0);
    k = 8'($random(seed)) & 8'h7f;
    request(1'b1, 1'b1, k, 1'b1);
    close_exch(1, 1, 1, 1, 2, 0, 1'b1, 1'b1);
    // Pass 0 is refused, pass 1 lets us choose the key, pass 2 names a specific key.
    for (int a = 0; a < 3; a++) begin
      REMOTE_REKEY_ALLOW_I = (a != 0);
      k = 8'($random(seed)) & 8'h7f;
      KEY_INDEX_I = k;
      rkey = (a == 2) ? (k ^ 8'h55) : 8'hff;
      exp_key = (a == 2) ? rkey : k;
      exp_df = 1'b1;
      remote = 1'b1;
      @(negedge CLK_I);
      remote = 1'b0;
      if (a == 0) repeat (120) @(negedge CLK_I);
      else await_disc(1'b1, 200);
      close_exch(a > 0, a > 0, a > 0, a > 0, (a > 0) ? 2 : 0, 0, 1'b1, 1'b1);
    end
    request(1'b0, 1'b0, 8'h00, 1'b1);
    close_exch(1, 1, 0, 0, 1, 0, 1'b0, 1'b0);
    request(1'b0, 1'b0, 8'h00, 1'b0);
    close_exch(0, 0, 0, 0, 0, 0, 1'b0, 1'b0);
    mode = 2'h2;
    request(1'b1, 1'b1, k, 1'b1);
    close_exch(0, 0, 1, 0, 1, 0, 1'b0, 1'b0);
    repeat (120) @(negedge CLK_I);
    mode = 2'h0;
    request(1'b1, 1'b0, 8'h00, 1'b1);
    close_exch(0, 0, 1, 1, 1, 0, 1'b1, 1'b0);
    mode = 2'h1;
    request(1'b0, 1'b0, 8'h00, 1'b1);
    close_exch(5, 0, 0, 0, 0, 1, 1'b0, 1'b0);
    mode = 2'h3;
    request(1'b1, 1'b1, k, 1'b1);
    await_disc(1'b0, 3000);
    check("start repeats above five", got_q.size() > 5, 1);
    check("drop near limit", (cyc - t0 >= 400) && (cyc - t0 <= 420), 1);
    got_q.delete();
    close_exch(0, 0, 0, 0, 0, 1, 1'b0, 1'b0);
    print_verdict();
  end

  // Every exchange here ends well inside this span, so reaching it means a hang.
  initial begin
    repeat (20000) @(negedge CLK_I);
    n_mismatch++;
    print_verdict();
  end
endmodule : cipher_mode_switch_ctrl_tb
